/* logic/cpc_consts.vh */
/*
 Constants for the card punch controller: instruction field positions,
 director function bits, status word bit positions and timing counts.
 Assumes inclusion by the design files only; holds definitions only.
*/
`ifndef CPC_CONSTS_VH
`define CPC_CONSTS_VH

// Q register fields
`define CPC_Q_DIR0        0
`define CPC_Q_DIR1        1
`define CPC_Q_ST_LO       5
`define CPC_Q_ST_HI       6
`define CPC_Q_EQ_LSB      7
`define CPC_Q_EQ_MSB      10
`define CPC_Q_W_LSB       11
`define CPC_Q_W_MSB       15

// Director function bits
`define CPC_FN_CLR_CTL    0
`define CPC_FN_CLR_INT    1
`define CPC_FN_DATA_IRQ   2
`define CPC_FN_CC_IRQ     3
`define CPC_FN_ALM_IRQ    4
`define CPC_FN_FEED       7
`define CPC_FN_OFFSET     8

// Controller status word bits
`define CPC_S1_READY      0
`define CPC_S1_BUSY       1
`define CPC_S1_INT        2
`define CPC_S1_DATA       3
`define CPC_S1_CC         4
`define CPC_S1_ALARM      5
`define CPC_S1_PROT       7
`define CPC_S1_ERR        8

// Punch status word bits
`define CPC_S2_HOPPER     0
`define CPC_S2_PERR       7
`define CPC_S2_STBY       8
`define CPC_S2_INHIBIT    9

// Card geometry and timing
`define CPC_LAST_COLUMN   7'h50
`define CPC_BUSY_DROP_NS  100
`define CPC_SYNC_IDLE     12'h04E
`define CPC_FIFO_DEPTH    4
`define CPC_FIFO_AW       2

`endif

/* logic/cpc_fifo.v */
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cpc_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             flush,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg  [AW-1:0]    wp_r;
   reg  [AW-1:0]    rp_r;
   reg  [AW:0]      cnt_r;
   wire             push;
   wire             pop;

   // Honest full and empty from the fill count
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Head word is read combinationally from the array
   always @* begin
      out_data = mem_r[rp_r];
   end

   // Pointers and count; flush empties the queue
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else if (flush) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // Storage
   always @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule // cpc_fifo

/* logic/cpc_top.v */
/*
 Card punch controller: decodes host instructions on the A/Q bus, keeps
 controller status, drives punch rows and interrupt responses.
 Assumes a host that presents q/a with a one-cycle read or write strobe,
 and a punch mechanism whose status lines are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "cpc_consts.vh"

// Behaviour
// (R1) Clear controller resets all, subordinate to A02-A08
// (R2) Clears run when not ready if alone
// (R3) Clear interrupt resets requests; new requests win
// (R4) Data interrupt: request and data status
// (R5) Card complete interrupt after accepted request
// (R6) Alarm interrupt, immediate if alarm exists
// (R7) Three responses plus their OR
// (R8) Feed starts cycle, suppresses card complete midcard
// (R9) Offset passed at once, cleared by acknowledge
// (R10) Status one accepted always, unused bits zero
// (R11) Ready is AND of punch conditions
// (R12) Busy from first column to column 80
// (R13) Interrupt status bit follows responses
// (R14) Data status set, cleared, re-set per column
// (R15) Card complete at column 80 or not-ready
// (R16) Alarm on not-ready, inhibit or punch error; code alarms on echo mismatch and never on punch_error
// (R17) Error on echo check mismatch
// (R18) Status two reports punch conditions
// (R19) Inhibit refuses punch data and feed
// (R20) External reject conditions
// (R21) Internal reject: silent on address mismatch
// (R22) Equipment field must match jumpers
// (R23) Protect jumper refuses unprotected writes
// (R24) Station code must be Q05=0, Q06=1
// (R25) Punch data rows from A00-A11
// (R26) Mixed function word rejected whole
// (R27) One outcome; state changes only on reply
module cpc_top (
   input  wire        sys_clk,
   input  wire        nrst,
   input  wire [15:0] q_bus,
   input  wire [15:0] a_in,
   input  wire        wr_strobe,
   input  wire        rd_strobe,
   input  wire        prot_instr,
   output reg  [15:0] a_out,
   output reg         reply,
   output reg         ext_reject,
   input  wire [3:0]  equip_jumper,
   input  wire        protect_jumper,
   input  wire        card_in_station,
   input  wire        punch_power,
   input  wire        punch_online,
   input  wire        stacker_full,
   input  wire        punch_jam,
   input  wire        interlock_closed,
   input  wire        hopper_empty,
   input  wire        punch_error,
   input  wire        punch_inhibit,
   input  wire        col_done,
   input  wire        feed_ack,
   input  wire        echo_mismatch,
   output reg  [11:0] punch_row_line,
   output reg         punch_strobe,
   output reg         feed_cmd,
   output reg         offset_cmd,
   output reg         data_int,
   output reg         card_complete_int,
   output reg         alarm_int,
   output wire        common_int
);
   reg         rst_s1_r;
   reg         rst_n;
   reg  [11:0] sy1_r;
   reg  [11:0] sy2_r;
   wire        ready;
   wire        inhibit_s;
   reg         busy_r;
   reg         data_st_r;
   reg         cc_st_r;
   reg         alarm_st_r;
   reg         err_st_r;
   reg         data_irq_r;
   reg         cc_irq_r;
   reg         alm_irq_r;
   reg         in_card_r;
   reg  [6:0]  col_cnt_r;
   reg  [6:0]  sent_cnt_r;
   reg         trunc_r;
   reg         pend_r;
   reg         col_done_d_r;
   wire        col_edge;
   wire        addr_ok;
   wire        is_rd;
   wire        is_wr;
   wire        op_data;
   wire        op_func;
   wire        op_s1;
   wire        op_s2;
   wire        fn_other;
   reg         accept;
   reg         xrej;
   wire        f_clrc;
   wire        f_clri;
   wire        f_feed;
   wire        data_acc;
   wire [11:0] fifo_q;
   wire        fifo_v;
   wire        fifo_rdy;
   wire        fifo_pop;
   wire        cc_set;
   wire        clr_all;
   wire        notready_fall;
   reg         ready_d_r;

   // Reset release through two flip-flops
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // Punch status pins pass two flip-flops
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_r <= `CPC_SYNC_IDLE;
         sy2_r <= `CPC_SYNC_IDLE;
      end else begin
         sy1_r <= {hopper_empty, echo_mismatch, col_done, punch_inhibit, punch_error,
                   interlock_closed, punch_jam, stacker_full, punch_online,
                   punch_power, card_in_station, feed_ack};
         sy2_r <= sy1_r;
      end
   end

   assign ready     = sy2_r[1] & sy2_r[2] & sy2_r[3] & ~sy2_r[4]
                      & ~sy2_r[5] & sy2_r[6]; // R11
   assign inhibit_s = sy2_r[8];
   assign col_edge  = sy2_r[9] & ~col_done_d_r;

   // Instruction decode
   assign addr_ok  = (q_bus[`CPC_Q_EQ_MSB:`CPC_Q_EQ_LSB] == equip_jumper) // R22
                     & ~q_bus[`CPC_Q_ST_LO] & q_bus[`CPC_Q_ST_HI]           // R24
                     & (q_bus[`CPC_Q_W_MSB:`CPC_Q_W_LSB] == 5'h00);         // R21
   assign is_rd    = rd_strobe & addr_ok;
   assign is_wr    = wr_strobe & addr_ok;
   assign op_data  = is_wr & ~q_bus[`CPC_Q_DIR0] & ~q_bus[`CPC_Q_DIR1];
   assign op_func  = is_wr & q_bus[`CPC_Q_DIR0] & ~q_bus[`CPC_Q_DIR1];
   assign op_s1    = is_rd & q_bus[`CPC_Q_DIR0] & ~q_bus[`CPC_Q_DIR1];
   assign op_s2    = is_rd & q_bus[`CPC_Q_DIR0] & q_bus[`CPC_Q_DIR1];
   assign fn_other = |a_in[`CPC_FN_OFFSET:`CPC_FN_DATA_IRQ];

   // Accept or external reject, exactly one per addressed strobe
   always @* begin
      accept = 1'b0;
      xrej   = 1'b0;
      if (is_rd) begin
         if (!q_bus[`CPC_Q_DIR0]) begin
            xrej = 1'b1; // R20
         end else begin
            accept = 1'b1; // R10
         end
      end else if (is_wr) begin
         if (q_bus[`CPC_Q_DIR1]) begin
            xrej = 1'b1; // R20
         end else if (protect_jumper & ~prot_instr) begin
            xrej = 1'b1; // R23
         end else if (op_data) begin
            xrej   = ~data_st_r | inhibit_s | ~fifo_rdy; // R19
            accept = ~xrej;
         end else begin
            // Whole word refused if any part is refused
            xrej   = (fn_other & ~ready)
                     | (a_in[`CPC_FN_FEED] & inhibit_s); // R26
            accept = ~xrej; // R2
         end
      end
   end

   assign f_clrc   = accept & op_func & a_in[`CPC_FN_CLR_CTL]; // R1
   assign f_clri   = accept & op_func & a_in[`CPC_FN_CLR_INT]; // R3
   assign f_feed   = accept & op_func & a_in[`CPC_FN_FEED];    // R8
   assign data_acc = accept & op_data;
   assign clr_all  = f_clrc;

   // Rows queued toward the punch
   cpc_fifo #(
      .WIDTH (12),
      .DEPTH (`CPC_FIFO_DEPTH),
      .AW    (`CPC_FIFO_AW)
   ) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .flush     (clr_all),
      .in_data   (a_in[11:0]), // R25
      .in_valid  (data_acc),
      .in_ready  (fifo_rdy),
      .out_data  (fifo_q),
      .out_valid (fifo_v),
      .out_ready (fifo_pop)
   );
   assign fifo_pop = fifo_v & ~pend_r & ready & ~inhibit_s;

   assign cc_set        = col_edge & pend_r & ~trunc_r
                          & (col_cnt_r == `CPC_LAST_COLUMN - 7'h01);
   assign notready_fall = ready_d_r & ~ready & in_card_r;

   // Host answer registers
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reply      <= 1'b0;
         ext_reject <= 1'b0;
         a_out      <= 16'h0000;
      end else begin
         reply      <= accept; // R27
         ext_reject <= xrej;   // R20
         if (op_s1 & accept) begin
            a_out <= {7'h00, err_st_r, protect_jumper, 1'b0, alarm_st_r,
                      cc_st_r, data_st_r, common_int, busy_r, ready}; // R10
         end else if (op_s2 & accept) begin
            a_out <= {6'h00, inhibit_s, ~sy2_r[3], sy2_r[7], 6'h00,
                      sy2_r[11]}; // R18
         end
      end
   end

   // Controller and interrupt state
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r       <= 1'b0;
         data_st_r    <= 1'b1;
         cc_st_r      <= 1'b0;
         alarm_st_r   <= 1'b0;
         err_st_r     <= 1'b0;
         data_irq_r   <= 1'b0;
         cc_irq_r     <= 1'b0;
         alm_irq_r    <= 1'b0;
         in_card_r    <= 1'b0;
         col_cnt_r    <= 7'h00;
         sent_cnt_r   <= 7'h00;
         trunc_r      <= 1'b0;
         pend_r       <= 1'b0;
         col_done_d_r <= 1'b0;
         ready_d_r    <= 1'b0;
         punch_row_line <= 12'h000;
         punch_strobe <= 1'b0;
         feed_cmd     <= 1'b0;
         offset_cmd   <= 1'b0;
         data_int     <= 1'b0;
         card_complete_int <= 1'b0;
         alarm_int    <= 1'b0;
      end else begin
         col_done_d_r <= sy2_r[9];
         ready_d_r    <= ready;
         punch_strobe <= 1'b0;
         // Clears first; later requests in the same word override
         if (f_clrc | f_clri) begin
            data_irq_r <= 1'b0; // R3
            cc_irq_r   <= 1'b0;
            alm_irq_r  <= 1'b0;
            data_int   <= 1'b0;
            card_complete_int <= 1'b0;
            alarm_int  <= 1'b0;
         end
         if (f_clrc) begin
            busy_r     <= 1'b0; // R1
            data_st_r  <= ready; // R14
            cc_st_r    <= 1'b0;
            alarm_st_r <= 1'b0;
            err_st_r   <= 1'b0;
            in_card_r  <= 1'b0;
            col_cnt_r  <= 7'h00;
            sent_cnt_r <= 7'h00;
            trunc_r    <= 1'b0;
            pend_r     <= 1'b0;
            feed_cmd   <= 1'b0;
            offset_cmd <= 1'b0;
         end
         // Interrupt requests, subordinate clears lose
         if (accept & op_func & a_in[`CPC_FN_DATA_IRQ]) begin
            data_irq_r <= 1'b1; // R4
         end
         if (accept & op_func & a_in[`CPC_FN_CC_IRQ]) begin
            cc_irq_r <= 1'b1; // R5
         end
         if (accept & op_func & a_in[`CPC_FN_ALM_IRQ]) begin
            alm_irq_r <= 1'b1; // R6
         end
         if (accept & op_func & a_in[`CPC_FN_OFFSET]) begin
            offset_cmd <= 1'b1; // R9
         end else if (sy2_r[0]) begin
            offset_cmd <= 1'b0; // R9
         end
         // Feed: new card, clears card status
         if (f_feed) begin
            feed_cmd   <= 1'b1; // R8
            data_st_r  <= 1'b0; // R14
            cc_st_r    <= 1'b0; // R15
            alarm_st_r <= 1'b0; // R16
            err_st_r   <= 1'b0; // R17
            data_int   <= 1'b0;
            card_complete_int <= 1'b0;
            alarm_int  <= 1'b0;
            if (in_card_r) begin
               trunc_r <= 1'b1; // R8
            end
         end else if (feed_cmd & sy2_r[0]) begin
            feed_cmd   <= 1'b0;
            data_st_r  <= ~inhibit_s; // R14
            col_cnt_r  <= 7'h00;
            sent_cnt_r <= 7'h00;
            trunc_r    <= 1'b0;
            in_card_r  <= 1'b0;
         end
         // Punch data taken
         if (data_acc) begin
            data_st_r  <= 1'b0; // R14
            data_int   <= 1'b0; // R4
            busy_r     <= 1'b1; // R12
            in_card_r  <= 1'b1;
            sent_cnt_r <= sent_cnt_r + 7'h01;
         end
         // Column to the punch
         if (fifo_pop) begin
            punch_row_line <= fifo_q;
            punch_strobe   <= 1'b1;
            pend_r         <= 1'b1;
         end
         if (col_edge & pend_r) begin
            pend_r    <= 1'b0;
            col_cnt_r <= col_cnt_r + 7'h01;
            if (sy2_r[10]) begin
               err_st_r   <= 1'b1; // R17
               alarm_st_r <= 1'b1; // R16
            end
            if (cc_set) begin
               cc_st_r   <= 1'b1; // R15
               busy_r    <= 1'b0; // R12
               in_card_r <= 1'b0;
            end else if (trunc_r & (col_cnt_r + 7'h01 == sent_cnt_r)) begin
               busy_r <= 1'b0; // R12
            end else if (!trunc_r & !feed_cmd & !data_acc) begin
               data_st_r <= 1'b1; // R14
            end
         end
         // Punch lost while a card is in process
         if (notready_fall | (inhibit_s & in_card_r)) begin
            alarm_st_r <= 1'b1; // R16
            busy_r     <= 1'b0; // R12
            in_card_r  <= 1'b0;
            if (notready_fall) begin
               cc_st_r <= 1'b1; // R15
            end
         end
         if (!ready | inhibit_s) begin
            data_st_r <= 1'b0; // R14
            busy_r    <= 1'b0; // R12
         end
         // Responses from requests and status
         if (data_irq_r & data_st_r & ~data_acc & ~f_feed & ~f_clrc & ~f_clri) begin
            data_int <= 1'b1; // R4
         end
         if (cc_irq_r & cc_set) begin
            card_complete_int <= 1'b1; // R5
         end
         if (alm_irq_r & alarm_st_r & ~f_feed & ~f_clrc & ~f_clri) begin
            alarm_int <= 1'b1; // R6
         end
      end
   end

   assign common_int = data_int | card_complete_int | alarm_int; // R7 R13
endmodule // cpc_top

/* verification/cpc_checker.sv */
/* Concurrent checks on the host bus side of the card punch controller.
   Assumes it is bound to cpc_top and sees only that module's ports. */
`timescale 1ns/1ps
module cpc_checker (
   input wire        sys_clk,
   input wire        nrst,
   input wire [15:0] q_bus,
   input wire [15:0] a_out,
   input wire        wr_strobe,
   input wire        rd_strobe,
   input wire        prot_instr,
   input wire        reply,
   input wire        ext_reject,
   input wire [3:0]  equip_jumper,
   input wire        protect_jumper,
   input wire        data_int,
   input wire        card_complete_int,
   input wire        alarm_int,
   input wire        common_int
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Addressed to this controller
   wire hit = q_bus[10:7] == equip_jumper && q_bus[6:5] == 2'b10 && q_bus[15:11] == 5'h00;
   wire req = wr_strobe || rd_strobe;
   // Accepted status one read and its answer
   sequence s1_rd;
      rd_strobe && hit && q_bus[1:0] == 2'b01;
   endsequence
   sequence s1_done;
      s1_rd ##1 reply;
   endsequence
   idle_silent_a: assert property (!req |=> !reply && !ext_reject)
      else $error("outcome without instruction");
   one_outcome_a: assert property (!(reply && ext_reject))
      else $error("reply and reject together");
   equip_silent_a: assert property (req && q_bus[10:7] != equip_jumper
      |=> !reply && !ext_reject) else $error("answer to foreign equipment");
   station_silent_a: assert property (req && q_bus[6:5] != 2'b10 |=> !reply && !ext_reject)
      else $error("answer to wrong station");
   w_field_a: assert property (req && q_bus[15:11] != 5'h00 |=> !reply && !ext_reject)
      else $error("answer with W field set");
   read_dir_a: assert property (rd_strobe && hit && !q_bus[0] |=> ext_reject)
      else $error("read with Q00 low not rejected");
   write_dir_a: assert property (wr_strobe && hit && q_bus[1] |=> ext_reject)
      else $error("write with Q01 high not rejected");
   status_accept_a: assert property (rd_strobe && hit && q_bus[0] |=> reply)
      else $error("status read not accepted");
   status_zero_a: assert property (s1_done |-> a_out[6] == 1'b0 && a_out[15:9] == 7'h00)
      else $error("unused status bits not zero");
   prot_bit_a: assert property (s1_done |-> a_out[7] == protect_jumper)
      else $error("protect status wrong");
   protect_bar_a: assert property (wr_strobe && hit && protect_jumper && !prot_instr
      |=> ext_reject) else $error("unprotected write accepted");
   common_or_a: assert property (common_int == (data_int || card_complete_int || alarm_int))
      else $error("common interrupt not the OR");
endmodule // cpc_checker

bind cpc_top cpc_checker u_chk (.sys_clk, .nrst, .q_bus, .a_out, .wr_strobe, .rd_strobe,
   .prot_instr, .reply, .ext_reject, .equip_jumper, .protect_jumper, .data_int,
   .card_complete_int, .alarm_int, .common_int);

/* verification/cpc_punch_model.sv */
/* Behavioural card punch: punches a column after a lag, answers feeds.
   Assumes the controller holds each row word until col_done rises. */
`timescale 1ns/1ps
module cpc_punch_model (
   input  wire        sys_clk,
   input  wire        punch_strobe,
   input  wire        feed_cmd,
   input  wire [11:0] punch_row_line,
   input  wire        bad_echo,
   input  wire [3:0]  lag,
   output reg         col_done,
   output reg         feed_ack,
   output reg         echo_mismatch,
   output reg  [11:0] last_rows
);
   // Column cycle: latch rows, report done with echo after a lag
   initial begin
      col_done = 1'b0;
      echo_mismatch = 1'b0;
      last_rows = 12'h000;
      forever begin
         @(posedge sys_clk);
         if (punch_strobe === 1'b1) begin
            last_rows = punch_row_line;
            repeat (lag) @(negedge sys_clk);
            echo_mismatch = bad_echo;
            col_done = 1'b1;
            repeat (3) @(negedge sys_clk);
            col_done = 1'b0;
            echo_mismatch = 1'b0;
         end
      end
   end
   // Feed cycle: acknowledge after lag until the command drops
   initial begin
      feed_ack = 1'b0;
      forever begin
         @(negedge sys_clk);
         if (feed_cmd === 1'b1) begin
            repeat (lag) @(negedge sys_clk);
            feed_ack = 1'b1;
            while (feed_cmd === 1'b1) @(negedge sys_clk);
            feed_ack = 1'b0;
         end
      end
   end
endmodule // cpc_punch_model

/* verification/tb.sv */
/* Self-checking bench for the card punch controller: scenario tasks
   drive the host bus at the falling edge and judge outcomes and status.
   Assumes the design, checker and punch model compile with it. */
`timescale 1ns/1ps
module tb;
   localparam [3:0] EQ = 4'hA;
   reg        sys_clk = 1'b0, nrst = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
   reg        prot_instr = 1'b0, protect_jumper = 1'b0, hopper_empty = 1'b1;
   reg        punch_inhibit = 1'b0, bad_echo = 1'b0;
   reg [15:0] q_bus = 16'h0000, a_in = 16'h0000, s;
   reg [5:0]  cnd = 6'h3F;
   reg [3:0]  lag = 4'h1;
   reg [1:0]  r;
   integer    miscompares = 0, check_count = 0;
   wire [15:0] a_out;
   wire [11:0] punch_row_line, rows;
   wire       reply, ext_reject, punch_strobe, feed_cmd, offset_cmd, col_done, feed_ack;
   wire       echo_mismatch, data_int, card_complete_int, alarm_int, common_int;
   // Clock
   always #50 sys_clk = ~sys_clk;
   cpc_top dut (.sys_clk, .nrst, .q_bus, .a_in, .wr_strobe, .rd_strobe, .prot_instr,
      .a_out, .reply, .ext_reject, .equip_jumper(EQ), .protect_jumper,
      .card_in_station(cnd[0]), .punch_power(cnd[1]), .punch_online(cnd[2]),
      .stacker_full(!cnd[3]), .punch_jam(!cnd[4]), .interlock_closed(cnd[5]),
      .hopper_empty, .punch_error(punch_inhibit), .punch_inhibit, .col_done, .feed_ack,
      .echo_mismatch, .punch_row_line, .punch_strobe, .feed_cmd, .offset_cmd, .data_int,
      .card_complete_int, .alarm_int, .common_int);
   cpc_punch_model u_punch (.sys_clk, .punch_strobe, .feed_cmd, .punch_row_line,
      .bad_echo, .lag, .col_done, .feed_ack, .echo_mismatch, .last_rows(rows));
   // Instruction word: W zero, our equipment, station Q06 high Q05 low
   function [15:0] qw(input [1:0] d);
      qw = {5'h00, EQ, 2'b10, 3'h0, d};
   endfunction
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task settle(input integer n);
      repeat (n) @(negedge sys_clk);
   endtask
   // One instruction: strobe one cycle, take the outcome next cycle
   task ox(input w, input [1:0] d, input [15:0] qx, input [15:0] a, input [1:0] e);
      begin
         @(negedge sys_clk);
         q_bus = qw(d) ^ qx;
         a_in = a;
         wr_strobe = w;
         rd_strobe = !w;
         @(negedge sys_clk);
         wr_strobe = 1'b0;
         rd_strobe = 1'b0;
         r = {ext_reject, reply};
         s = a_out;
         chk("outcome", e, r);
         settle(2);
      end
   endtask
   task fn(input [15:0] a, input [1:0] e);
      ox(1'b1, 2'b01, 16'h0000, a, e);
   endtask
   task pd(input [15:0] a, input [1:0] e);
      ox(1'b1, 2'b00, 16'h0000, a, e);
   endtask
   task rd(input [1:0] d);
      ox(1'b0, d, 16'h0000, 16'h0000, 2'b01);
   endtask
   // Poll status one until a bit reaches a level, bounded
   task wait_st(input integer b, input v);
      integer n;
      begin
         n = 0;
         rd(2'b01);
         while (s[b] !== v && n < 60) begin
            rd(2'b01);
            n = n + 1;
         end
         chk("status bit", v, s[b]);
      end
   endtask
   task t_basic;
      begin
         rd(2'b01);
         chk("ready", 1'b1, s[0]);
         chk("data", 1'b1, s[3]);
         chk("busy", 1'b0, s[1]);
         rd(2'b11);
         chk("hopper", 1'b1, s[0]);
         chk("inhibit", 1'b0, s[9]);
      end
   endtask
   task t_addr;
      begin
         ox(1'b1, 2'b01, 16'h0080, 16'h0001, 2'b00);
         ox(1'b0, 2'b01, 16'h0060, 16'h0000, 2'b00);
         ox(1'b0, 2'b01, 16'h0800, 16'h0000, 2'b00);
         ox(1'b0, 2'b00, 16'h0000, 16'h0000, 2'b10);
         ox(1'b1, 2'b10, 16'h0000, 16'h0000, 2'b10);
      end
   endtask
   // Full card with armed interrupts and an echo fault, then a feed
   task t_card;
      integer i;
      begin
         fn(16'h000C, 2'b01);
         chk("data_int", 1'b1, data_int);
         chk("common", 1'b1, common_int);
         for (i = 0; i < 80; i = i + 1) begin
            bad_echo = (i == 5);
            pd({4'hF, i[5:0], ~i[5:0]}, 2'b01);
            if (i < 79) begin
               wait_st(3, 1'b1);
               chk("rows", {i[5:0], ~i[5:0]}, rows);
               chk("busy", 1'b1, s[1]);
            end
         end
         wait_st(4, 1'b1);
         chk("rows", 12'h3F0, rows);
         chk("busy", 1'b0, s[1]);
         chk("data", 1'b0, s[3]);
         chk("error", 1'b1, s[8]);
         chk("alarm", 1'b1, s[5]);
         chk("cc_int", 1'b1, card_complete_int);
         chk("data_int", 1'b0, data_int);
         pd(16'h0001, 2'b10);
         fn(16'h0080, 2'b01);
         wait_st(3, 1'b1);
         chk("cc", 1'b0, s[4]);
         chk("alarm", 1'b0, s[5]);
         chk("error", 1'b0, s[8]);
         chk("cc_int", 1'b0, card_complete_int);
         chk("data_int", 1'b1, data_int);
         fn(16'h0002, 2'b01);
         chk("data_int", 1'b0, data_int);
      end
   endtask
   // Offset, slow punch, feed in mid card
   task t_mid;
      begin
         lag = 4'h6;
         fn(16'h0100, 2'b01);
         chk("offset", 1'b1, offset_cmd);
         pd(16'h0ABC, 2'b01);
         fn(16'h0080, 2'b01);
         wait_st(3, 1'b1);
         chk("cc", 1'b0, s[4]);
         chk("busy", 1'b0, s[1]);
         chk("offset", 1'b0, offset_cmd);
         chk("rows", 12'hABC, rows);
         lag = 4'h1;
      end
   endtask
   task t_inh;
      begin
         punch_inhibit = 1'b1;
         settle(5);
         rd(2'b11);
         chk("inhibit", 1'b1, s[9]);
         chk("perr", 1'b1, s[7]);
         pd(16'h0001, 2'b10);
         fn(16'h0080, 2'b10);
         punch_inhibit = 1'b0;
         settle(5);
         fn(16'h0080, 2'b01);
         wait_st(3, 1'b1);
      end
   endtask
   // Not ready in mid card, refusals, alarm interrupt, clears
   task t_nrdy;
      integer i;
      begin
         pd(16'h0001, 2'b01);
         wait_st(3, 1'b1);
         cnd = 6'h3E;
         settle(5);
         rd(2'b01);
         chk("ready", 1'b0, s[0]);
         chk("alarm", 1'b1, s[5]);
         chk("cc", 1'b1, s[4]);
         chk("busy", 1'b0, s[1]);
         chk("data", 1'b0, s[3]);
         fn(16'h0010, 2'b10);
         fn(16'h0081, 2'b10);
         rd(2'b01);
         chk("alarm", 1'b1, s[5]);
         fn(16'h0002, 2'b01);
         cnd = 6'h3F;
         settle(5);
         fn(16'h0010, 2'b01);
         chk("alarm_int", 1'b1, alarm_int);
         chk("common", 1'b1, common_int);
         fn(16'h0012, 2'b01);
         chk("alarm_int", 1'b1, alarm_int);
         fn(16'h0002, 2'b01);
         chk("alarm_int", 1'b0, alarm_int);
         for (i = 1; i < 6; i = i + 1) begin
            cnd = 6'h3F ^ (6'h01 << i);
            settle(5);
            rd(2'b01);
            chk("ready", 1'b0, s[0]);
         end
         cnd = 6'h3F;
         settle(5);
         fn(16'h0001, 2'b01);
         wait_st(3, 1'b1);
         chk("alarm", 1'b0, s[5]);
         chk("cc", 1'b0, s[4]);
      end
   endtask
   task t_prot;
      begin
         protect_jumper = 1'b1;
         settle(3);
         fn(16'h0002, 2'b10);
         rd(2'b01);
         chk("protect", 1'b1, s[7]);
         prot_instr = 1'b1;
         fn(16'h0002, 2'b01);
         prot_instr = 1'b0;
         protect_jumper = 1'b0;
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   // Reset, then the scenarios
   initial begin
      settle(16);
      nrst = 1'b1;
      settle(5);
      t_basic;
      t_addr;
      t_card;
      t_mid;
      t_inh;
      t_nrdy;
      t_prot;
      close_out;
   end
   // Watchdog for a hung run
   initial begin
      #3000000;
      miscompares = miscompares + 1;
      close_out;
   end
endmodule // tb
